//--- ssfs_fifo.sv
// small first-in first-out store with registered read word and level count
`timescale 1ns/1ps
module ssfs_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8,
   parameter int LW    = 4
) (
   input  wire logic          core_clk,
   input  wire logic          nrst,
   input  wire logic          clear,
   input  wire logic          push,
   input  wire logic [W-1:0]  wdata,
   input  wire logic          pop,
   output logic      [W-1:0]  rdata,
   output logic      [LW-1:0] level
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           rp;
      logic [PW-1:0]           wp;
      logic [LW-1:0]           lvl;
      logic [W-1:0]            rd;
   } ssfs_fifo_st_t;

   ssfs_fifo_st_t s;
   ssfs_fifo_st_t next_s;
   logic          do_push;
   logic          do_pop;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : ptr_inc

   always_comb begin
      next_s  = s;
      do_push = push & (s.lvl != LW'(DEPTH));
      do_pop  = pop & (s.lvl != '0);
      if (clear) begin
         next_s.rp  = '0;
         next_s.wp  = '0;
         next_s.lvl = '0;
      end else begin
         if (do_push) begin
            next_s.mem[s.wp] = wdata;
            next_s.wp        = ptr_inc(s.wp);
         end
         if (do_pop) begin
            next_s.rp = ptr_inc(s.rp);
         end
         if (do_push && !do_pop) begin
            next_s.lvl = s.lvl + 1'b1;
         end else if (do_pop && !do_push) begin
            next_s.lvl = s.lvl - 1'b1;
         end
      end
      // bypass so a word pushed into an empty store is readable next cycle
      if (!clear && do_push && (s.wp == next_s.rp)) begin
         next_s.rd = wdata;
      end else begin
         next_s.rd = s.mem[next_s.rp];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rd;
   assign level = s.lvl;

   chk_level_bound: assert property (@(posedge core_clk) disable iff (!nrst)
      s.lvl <= LW'(DEPTH)) else $error("fifo level above depth");

endmodule : ssfs_fifo

//--- ssfs_link_model.sv
// serial link master model that clocks one word per frame into the port
`timescale 1ns/1ps
module ssfs_link_model (
   output logic      link_clk,
   output logic      link_frame_n,
   output logic      link_rxd,
   input  wire logic link_txd
);
   initial begin
      link_clk     = 1'b0;
      link_frame_n = 1'b1;
      link_rxd     = 1'b0;
   end
   // clock idles low outside frames, msb first, data sampled on the rise
   task automatic xfer(input logic [15:0] out, input int n, output logic [15:0] got);
      got = 16'h0000;
      link_frame_n = 1'b0;
      #100;
      for (int i = n - 1; i >= 0; i--) begin
         link_rxd = out[i];
         #40 link_clk = 1'b1;
         got = {got[14:0], link_txd};
         #40 link_clk = 1'b0;
      end
      #100 link_frame_n = 1'b1;
      // a released line must not keep showing the last bit
      link_rxd = ~link_rxd;
      #60;
   endtask : xfer
endmodule : ssfs_link_model

//--- ssfs_link_shift.sv
// serial word shifter driven by an externally supplied link clock
`timescale 1ns/1ps
module ssfs_link_shift (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        enable,
   input  wire logic        loopback,
   input  wire logic [4:0]  rx_bits,
   input  wire logic [4:0]  tx_bits,
   input  wire logic        tx_empty,
   input  wire logic [15:0] tx_word,
   input  wire logic        link_clk,
   input  wire logic        link_frame_n,
   input  wire logic        link_rxd,
   output logic             link_txd,
   output logic             busy,
   output logic             tx_pop,
   output logic             rx_push,
   output logic [15:0]      rx_word
);
   typedef struct packed {
      logic [2:0]             m1;
      logic [2:0]             m2;
      logic                   clk_d;
      ssfs_pkg::ssfs_link_st_t st;
      logic [15:0]            tsh;
      logic [15:0]            rsh;
      logic [4:0]             cnt;
      logic                   txd;
      logic                   pop;
      logic                   push;
      logic [15:0]            rw;
      logic                   have;
      logic                   reload;
   } ssfs_link_t;

   ssfs_link_t s;
   ssfs_link_t next_s;
   logic       rise;
   logic       fall;
   logic       active;
   logic       rxbit;

   // unused upper bits are dropped, the word leaves msb first
   function automatic logic [15:0] align(input logic [15:0] w, input logic [4:0] bits);
      align = w << (ssfs_pkg::FULL_WORD_BITS - bits);
   endfunction : align

   function automatic logic [15:0] low_mask(input logic [4:0] bits);
      low_mask = 16'hffff >> (ssfs_pkg::FULL_WORD_BITS - bits);
   endfunction : low_mask

   always_comb begin
      next_s       = s;
      next_s.m1    = {link_clk, link_frame_n, link_rxd};
      next_s.m2    = s.m1;
      next_s.clk_d = s.m2[2];
      next_s.pop   = 1'b0;
      next_s.push  = 1'b0;
      rise   = s.m2[2] & ~s.clk_d;
      fall   = ~s.m2[2] & s.clk_d;
      active = enable & ~s.m2[1];
      rxbit  = loopback ? s.txd : s.m2[0];
      case (s.st)
         ssfs_pkg::LK_IDLE: begin
            next_s.cnt    = '0;
            next_s.reload = 1'b0;
            if (active) begin
               // the head word leaves the fifo only once rx_bits bits have been clocked, so a cut
               // frame leaves it in place to be sent again
               next_s.st   = ssfs_pkg::LK_SHIFT;
               next_s.tsh  = tx_empty ? 16'h0000 : align(tx_word, tx_bits);
               next_s.have = ~tx_empty;
            end
         end
         ssfs_pkg::LK_SHIFT: begin
            if (!active) begin
               next_s.st  = ssfs_pkg::LK_IDLE;
               next_s.cnt = '0;
            end else if (rise) begin
               next_s.rsh = {s.rsh[14:0], rxbit};
               if (s.cnt == rx_bits - 5'h01) begin
                  next_s.push   = 1'b1;
                  next_s.rw     = next_s.rsh & low_mask(rx_bits);
                  next_s.cnt    = '0;
                  next_s.pop    = s.have;
                  next_s.have   = 1'b0;
                  next_s.reload = 1'b1;
               end else begin
                  next_s.cnt = s.cnt + 5'h01;
               end
            end else if (fall && s.reload) begin
               // next word replaces the shift at the fall that ends the last bit
               next_s.tsh    = tx_empty ? 16'h0000 : align(tx_word, tx_bits);
               next_s.have   = ~tx_empty;
               next_s.reload = 1'b0;
            end else if (fall) begin
               next_s.tsh = {s.tsh[14:0], 1'b0};
            end
         end
         default: begin
            next_s.st = ssfs_pkg::LK_IDLE;
         end
      endcase
      next_s.txd = next_s.tsh[15];
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign link_txd = s.txd;
   assign busy     = (s.st == ssfs_pkg::LK_SHIFT);
   assign tx_pop   = s.pop;
   assign rx_push  = s.push;
   assign rx_word  = s.rw;

endmodule : ssfs_link_shift

//--- ssfs_pkg.sv
// shared constants for the serial port fifo, status and data window block
package ssfs_pkg;

   localparam int WORD_W     = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int LVL_W      = 4;
   localparam int ADDR_W     = 12;

   // byte addresses of the registers
   localparam logic [11:0] ADR_CTRL_ZERO = 12'h800;
   localparam logic [11:0] ADR_CTRL_ONE  = 12'h804;
   localparam logic [11:0] ADR_STATUS    = 12'h810;
   localparam logic [11:0] ADR_ITEST     = 12'h814;
   localparam logic [11:0] ADR_WIN_LO    = 12'h840;
   localparam logic [11:0] ADR_WIN_HI    = 12'h87c;

   // control register zero fields
   localparam int CR0_WSS_LSB = 0;
   localparam int CR0_FRF_LSB = 4;
   localparam int CR0_EN_BIT  = 7;

   // control register one fields
   localparam int CR1_RIM_BIT = 0;
   localparam int CR1_TIM_BIT = 1;
   localparam int CR1_LBM_BIT = 2;
   localparam int CR1_SPO_BIT = 3;
   localparam int CR1_SPH_BIT = 4;
   localparam int CR1_TFT_LSB = 7;
   localparam int CR1_RFT_LSB = 11;

   // status register fields, the same positions serve the test register
   localparam int SR_TNF_BIT = 2;
   localparam int SR_RNE_BIT = 3;
   localparam int SR_BSY_BIT = 4;
   localparam int SR_TFS_BIT = 5;
   localparam int SR_RFS_BIT = 6;
   localparam int SR_ROR_BIT = 7;
   localparam int SR_TFL_LSB = 8;
   localparam int SR_RFL_LSB = 12;

   // reset values
   localparam logic [3:0] THR_RESET = 4'h7;
   localparam logic [3:0] WSS_RESET = 4'h0;
   localparam logic [1:0] FRF_RESET = 2'h0;

   localparam logic [1:0] FRF_THREE_WIRE = 2'h2;
   localparam logic [4:0] THREE_WIRE_TX_BITS = 5'h08;
   localparam logic [4:0] FULL_WORD_BITS = 5'h10;

   typedef enum logic {LK_IDLE, LK_SHIFT} ssfs_link_st_t;

endpackage : ssfs_pkg

//--- ssfs_top.sv
// fifo, data window, status and interrupt request logic of the serial port
// Notes on behaviour
// - tx threshold field, four bits, resets to 0111, holds threshold minus one.
// - rx threshold field, four bits, resets to 0111, holds threshold minus one.
// - data window spans word addresses, 32-bit transfers, low 16 bits carry data.
// - window write pushes tx fifo, read pops rx fifo; full tx drops writes.
// - short words are right-justified both ways; unused upper tx bits ignored.
// - three-wire format sends eight bits; receive width follows word size.
// - both fifos empty on reset and when port enable is written zero.
// - status bit 2 shows tx fifo has room; no interrupt.
// - status bit 3 shows rx fifo holds data; no interrupt.
// - status bit 4 shows a frame in progress; clear when idle or disabled.
// - status bit 5 set when tx level at or below threshold; maskable request.
// - status bit 6 set when rx level at or above threshold; maskable request.
// - status bit 7 sticky on receive into full fifo; word dropped; unmasked request.
// - writing one clears the overrun bit and its request; zero leaves it.
// - every interrupt request is a level that follows its status bit.
// - status shows tx level in bits 11:8 and rx level in 15:12.
// - writes to read-only flags are ignored; reserved bits read zero.
// - writing one to a test register bit gives a one-shot strobe.
// - a clear mask blocks the request but the service flag keeps updating.
// - port enable bit 7 resets to zero; one enables the port.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module ssfs_top #(
   parameter int DEPTH = ssfs_pkg::FIFO_DEPTH
) (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic [11:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        link_clk,
   input  wire logic        link_frame_n,
   input  wire logic        link_rxd,
   output logic             link_txd,
   output logic             tx_irq,
   output logic             rx_irq,
   output logic             ror_irq,
   output logic             tx_test_strobe,
   output logic             rx_test_strobe,
   output logic             ror_test_strobe
);
   localparam int LW = ssfs_pkg::LVL_W;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic [3:0]  wss;
      logic [1:0]  frame_format_select;
      logic        en;
      logic        rx_irq_mask;
      logic        tim;
      logic        lbm;
      logic        spo;
      logic        sph;
      logic [3:0]  tx_threshold_field;
      logic [3:0]  rx_threshold_field;
      logic        ror;
      logic [2:0]  strobe;
   } ssfs_regs_t;

   ssfs_regs_t s;
   ssfs_regs_t next_s;

   logic          req;
   logic          wr_now;
   logic          rd_now;
   logic          win_hit;
   logic          fifo_clear;
   logic          tx_push;
   logic          rx_pop;
   logic          rx_ovf;
   logic          tx_not_full;
   logic          rx_not_empty;
   logic          tx_service_request;
   logic          rx_service_request;
   logic [31:0]   status;
   logic [LW-1:0] tx_lvl;
   logic [LW-1:0] rx_lvl;
   logic [15:0]   tx_rd;
   logic [15:0]   rx_rd;
   logic [15:0]   rx_word;
   logic          rx_push;
   logic          tx_pop;
   logic          busy;
   logic [4:0]    rx_bits;
   logic [4:0]    tx_bits;

   function automatic logic in_window(input logic [11:0] a);
      in_window = (a >= ssfs_pkg::ADR_WIN_LO) && (a <= ssfs_pkg::ADR_WIN_HI)
                  && (a[1:0] == 2'h0);
   endfunction : in_window

   // every access takes one wait state, so read data are always registered
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~s.ack;
   assign wr_now          = s.ack & avs_write;
   assign rd_now          = s.ack & avs_read;
   assign win_hit         = in_window(avs_address);

   assign tx_push    = wr_now & win_hit;
   assign rx_pop     = rd_now & win_hit & rx_not_empty;
   assign fifo_clear = wr_now && (avs_address == ssfs_pkg::ADR_CTRL_ZERO)
                       && !avs_writedata[ssfs_pkg::CR0_EN_BIT];
   assign rx_ovf     = rx_push & (rx_lvl == LW'(DEPTH));

   assign tx_not_full = (tx_lvl != LW'(DEPTH));
   assign rx_not_empty = (rx_lvl != '0);
   // thresholds are stored minus one, so compare against field plus one
   assign tx_service_request = s.en & ({1'b0, tx_lvl} <= ({1'b0, s.tx_threshold_field} + 5'h01));
   assign rx_service_request = s.en & ({1'b0, rx_lvl} >= ({1'b0, s.rx_threshold_field} + 5'h01));

   always_comb begin
      status = 32'h0000_0000;
      status[ssfs_pkg::SR_TNF_BIT] = tx_not_full;
      status[ssfs_pkg::SR_RNE_BIT] = rx_not_empty;
      status[ssfs_pkg::SR_BSY_BIT] = busy;
      status[ssfs_pkg::SR_TFS_BIT] = tx_service_request;
      status[ssfs_pkg::SR_RFS_BIT] = rx_service_request;
      status[ssfs_pkg::SR_ROR_BIT] = s.ror;
      status[ssfs_pkg::SR_TFL_LSB +: 4] = tx_lvl;
      status[ssfs_pkg::SR_RFL_LSB +: 4] = rx_lvl;
   end

   assign rx_bits = {1'b0, s.wss} + 5'h01;
   assign tx_bits = (s.frame_format_select == ssfs_pkg::FRF_THREE_WIRE) ?
                    ssfs_pkg::THREE_WIRE_TX_BITS : rx_bits;

   always_comb begin
      next_s        = s;
      next_s.ack    = req & ~s.ack;
      next_s.strobe = 3'h0;
      if (req && !s.ack && avs_read) begin
         if (avs_address == ssfs_pkg::ADR_CTRL_ZERO) begin
            next_s.rdata = 32'h0000_0000;
            next_s.rdata[ssfs_pkg::CR0_WSS_LSB +: 4] = s.wss;
            next_s.rdata[ssfs_pkg::CR0_FRF_LSB +: 2] = s.frame_format_select;
            next_s.rdata[ssfs_pkg::CR0_EN_BIT]       = s.en;
         end else if (avs_address == ssfs_pkg::ADR_CTRL_ONE) begin
            next_s.rdata = 32'h0000_0000;
            next_s.rdata[ssfs_pkg::CR1_RIM_BIT]      = s.rx_irq_mask;
            next_s.rdata[ssfs_pkg::CR1_TIM_BIT]      = s.tim;
            next_s.rdata[ssfs_pkg::CR1_LBM_BIT]      = s.lbm;
            next_s.rdata[ssfs_pkg::CR1_SPO_BIT]      = s.spo;
            next_s.rdata[ssfs_pkg::CR1_SPH_BIT]      = s.sph;
            next_s.rdata[ssfs_pkg::CR1_TFT_LSB +: 4] = s.tx_threshold_field;
            next_s.rdata[ssfs_pkg::CR1_RFT_LSB +: 4] = s.rx_threshold_field;
         end else if (avs_address == ssfs_pkg::ADR_STATUS) begin
            next_s.rdata = status;
         end else if (win_hit) begin
            // an empty receive fifo reads as zero and is not popped
            next_s.rdata = rx_not_empty ? {16'h0000, rx_rd} : 32'h0000_0000;
         end else begin
            next_s.rdata = 32'h0000_0000;
         end
      end
      if (wr_now) begin
         if (avs_address == ssfs_pkg::ADR_CTRL_ZERO) begin
            next_s.wss = avs_writedata[ssfs_pkg::CR0_WSS_LSB +: 4];
            next_s.frame_format_select = avs_writedata[ssfs_pkg::CR0_FRF_LSB +: 2];
            next_s.en  = avs_writedata[ssfs_pkg::CR0_EN_BIT];
         end else if (avs_address == ssfs_pkg::ADR_CTRL_ONE) begin
            next_s.rx_irq_mask = avs_writedata[ssfs_pkg::CR1_RIM_BIT];
            next_s.tim = avs_writedata[ssfs_pkg::CR1_TIM_BIT];
            next_s.lbm = avs_writedata[ssfs_pkg::CR1_LBM_BIT];
            next_s.spo = avs_writedata[ssfs_pkg::CR1_SPO_BIT];
            next_s.sph = avs_writedata[ssfs_pkg::CR1_SPH_BIT];
            next_s.tx_threshold_field = avs_writedata[ssfs_pkg::CR1_TFT_LSB +: 4];
            next_s.rx_threshold_field = avs_writedata[ssfs_pkg::CR1_RFT_LSB +: 4];
         end else if (avs_address == ssfs_pkg::ADR_ITEST) begin
            next_s.strobe = {avs_writedata[ssfs_pkg::SR_ROR_BIT],
                             avs_writedata[ssfs_pkg::SR_RFS_BIT],
                             avs_writedata[ssfs_pkg::SR_TFS_BIT]};
         end
      end
      // a new overrun in the clearing cycle wins over the clear
      if (rx_ovf) begin
         next_s.ror = 1'b1;
      end else if (wr_now && (avs_address == ssfs_pkg::ADR_STATUS)
                   && avs_writedata[ssfs_pkg::SR_ROR_BIT]) begin
         next_s.ror = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s     <= '0;
         s.wss <= ssfs_pkg::WSS_RESET;
         s.frame_format_select <= ssfs_pkg::FRF_RESET;
         s.tx_threshold_field <= ssfs_pkg::THR_RESET;
         s.rx_threshold_field <= ssfs_pkg::THR_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata    = s.rdata;
   assign tx_irq          = tx_service_request & s.tim;
   assign rx_irq          = rx_service_request & s.rx_irq_mask;
   assign ror_irq         = s.ror;
   assign tx_test_strobe  = s.strobe[0];
   assign rx_test_strobe  = s.strobe[1];
   assign ror_test_strobe = s.strobe[2];

   ssfs_fifo #(
      .W     (ssfs_pkg::WORD_W),
      .DEPTH (DEPTH),
      .LW    (LW)
   ) u_tx_fifo (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clear    (fifo_clear),
      .push     (tx_push),
      .wdata    (avs_writedata[15:0]),
      .pop      (tx_pop),
      .rdata    (tx_rd),
      .level    (tx_lvl)
   );

   ssfs_fifo #(
      .W     (ssfs_pkg::WORD_W),
      .DEPTH (DEPTH),
      .LW    (LW)
   ) u_rx_fifo (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clear    (fifo_clear),
      .push     (rx_push),
      .wdata    (rx_word),
      .pop      (rx_pop),
      .rdata    (rx_rd),
      .level    (rx_lvl)
   );

   ssfs_link_shift u_link (
      .core_clk     (core_clk),
      .nrst         (nrst),
      .enable       (s.en),
      .loopback     (s.lbm),
      .rx_bits      (rx_bits),
      .tx_bits      (tx_bits),
      .tx_empty     (tx_lvl == '0),
      .tx_word      (tx_rd),
      .link_clk     (link_clk),
      .link_frame_n (link_frame_n),
      .link_rxd     (link_rxd),
      .link_txd     (link_txd),
      .busy         (busy),
      .tx_pop       (tx_pop),
      .rx_push      (rx_push),
      .rx_word      (rx_word)
   );

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   chk_thr_reset: assert property (
      $rose(nrst) |-> (s.tx_threshold_field == 4'h7) && (s.rx_threshold_field == 4'h7))
      else $error("thresholds not 0111 after reset");

   chk_wait_once: assert property (
      (req && avs_waitrequest) |=> !avs_waitrequest)
      else $error("access not answered after one wait state");

   chk_full_drop: assert property (
      (tx_push && tx_lvl == 4'h8 && !tx_pop && !fifo_clear) |=> tx_lvl == 4'h8)
      else $error("write to full tx fifo changed level");

   chk_disable_flush: assert property (
      fifo_clear |=> (tx_lvl == 4'h0) && (rx_lvl == 4'h0) && !rx_not_empty)
      else $error("fifos not emptied on disable");

   chk_busy_off: assert property (
      !s.en ##1 !s.en |-> !busy)
      else $error("busy while port disabled");

   chk_tx_service: assert property (
      s.en && ({1'b0, tx_lvl} <= {1'b0, s.tx_threshold_field} + 5'h01) |-> status[5])
      else $error("tx service flag missing at threshold");

   chk_rx_mask: assert property (
      !s.rx_irq_mask |-> !rx_irq)
      else $error("masked rx request raised");

   chk_ror_sticky: assert property (
      rx_ovf |=> s.ror [*2] or (s.ror ##1 $fell(s.ror)))
      else $error("overrun bit not set on dropped word");

   chk_ror_w1c: assert property (
      (wr_now && avs_address == 12'h810 && avs_writedata[7] && !rx_ovf)
      |=> !ror_irq)
      else $error("overrun not cleared by write one");

   chk_strobe_pulse: assert property (
      $rose(tx_test_strobe) |=> !tx_test_strobe)
      else $error("test strobe longer than one cycle");

   chk_status_zero: assert property (
      (s.ack && avs_read && avs_address == 12'h810) |-> s.rdata[31:16] == 16'h0000
         && s.rdata[1:0] == 2'h0)
      else $error("reserved status bits not zero");

   chk_en_reset: assert property (
      $rose(nrst) |-> !s.en && !busy)
      else $error("port enabled after reset");

   chk_tnf_full: assert property (
      (tx_lvl == 4'h8) |-> !status[2])
      else $error("tx not full shown while full");

   chk_rne_flag: assert property (
      (rx_lvl != 4'h0) |-> status[3])
      else $error("rx not empty missing with data");

   chk_tx_push: assert property (
      (tx_push && tx_lvl != 4'h8 && !tx_pop && !fifo_clear)
      |=> tx_lvl == $past(tx_lvl) + 4'h1)
      else $error("window write did not enter tx fifo");

   chk_rx_pop: assert property (
      (rx_pop && !rx_push && !fifo_clear)
      |=> rx_lvl == $past(rx_lvl) - 4'h1)
      else $error("window read did not pop rx fifo");

   chk_rx_service: assert property (
      s.en && ({1'b0, rx_lvl} >= {1'b0, s.rx_threshold_field} + 5'h01) |-> status[6])
      else $error("rx service flag missing at threshold");

   chk_dis_service: assert property (
      !s.en |-> !status[5] && !status[6])
      else $error("service flag set while disabled");

   chk_ror_hold: assert property (
      s.ror && !(wr_now && avs_address == 12'h810 && avs_writedata[7]) |=> s.ror)
      else $error("overrun bit lost without write one");

   chk_irq_level: assert property (
      (tx_service_request && s.tim) |-> tx_irq)
      else $error("tx request not following its flag");

   chk_strobe_rx: assert property (
      (wr_now && avs_address == 12'h814 && avs_writedata[6]) |=> rx_test_strobe)
      else $error("rx test strobe missing");

   chk_level_fields: assert property (
      (s.ack && avs_read && avs_address == 12'h810)
      |-> s.rdata[15:12] == $past(rx_lvl) && s.rdata[11:8] == $past(tx_lvl))
      else $error("status level fields wrong");

endmodule : ssfs_top

//--- ssfs_top_test.sv
// self-checking bench for the serial port fifo, status and data window
`timescale 1ns/1ps
module ssfs_top_test;
   logic        core_clk, nrst, avs_read, avs_write, avs_waitrequest;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic        link_clk, link_frame_n, link_rxd, link_txd;
   logic        tx_irq, rx_irq, ror_irq, tx_stb, rx_stb, ror_stb;
   logic [3:0]  n_tx = 4'h0, n_rx = 4'h0, n_ror = 4'h0;
   logic [15:0] got;
   int          err_total = 0, n_compared = 0;

   ssfs_top i_dut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_clk(link_clk),
      .link_frame_n(link_frame_n), .link_rxd(link_rxd), .link_txd(link_txd),
      .tx_irq(tx_irq), .rx_irq(rx_irq), .ror_irq(ror_irq), .tx_test_strobe(tx_stb),
      .rx_test_strobe(rx_stb), .ror_test_strobe(ror_stb));
   ssfs_link_model u_link (.link_clk(link_clk), .link_frame_n(link_frame_n),
      .link_rxd(link_rxd), .link_txd(link_txd));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (tx_stb === 1'b1) n_tx <= n_tx + 4'h1;
      if (rx_stb === 1'b1) n_rx <= n_rx + 4'h1;
      if (ror_stb === 1'b1) n_ror <= n_ror + 4'h1;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // request holds until waitrequest is seen low at a rising edge; a hang ends at the watchdog
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rdc
   task automatic irqs(input logic [2:0] exp);
      chk({29'h0, tx_irq, rx_irq, ror_irq}, {29'h0, exp});
   endtask : irqs

   task automatic t_reset;
      rdc(12'h810, 32'h0000_0004);
      rdc(12'h804, 32'h0000_3b80);
      irqs(3'b000);
      bus(1'b1, 12'h810, 32'h80);
      bus(1'b1, 12'h804, 32'h983);
      bus(1'b1, 12'h800, 32'h8f);
      rdc(12'h810, 32'h0000_0024);
      irqs(3'b100);
   endtask : t_reset
   task automatic t_fill;
      for (int i = 0; i < 9; i++)
         bus(1'b1, 12'h840 + 12'(4 * i), (i < 8) ? 32'h1111 * (i + 1) : 32'hdead);
      rdc(12'h810, 32'h0000_0800);
      irqs(3'b000);
   endtask : t_fill
   task automatic t_link;
      for (int i = 0; i < 9; i++) begin
         u_link.xfer(16'hc3a0 + 16'(i), 16, got);
         chk({16'h0, got}, (i < 8) ? 32'h1111 * (i + 1) : 32'h0);
      end
      rdc(12'h810, 32'h0000_80ec);
      irqs(3'b111);
   endtask : t_link
   task automatic t_drain;
      bus(1'b1, 12'h804, 32'h982);
      rdc(12'h810, 32'h0000_80ec);
      irqs(3'b101);
      for (int i = 0; i < 8; i++)
         rdc(12'h87c, 32'hc3a0 + i);
      rdc(12'h840, 32'h0);
      rdc(12'h810, 32'h0000_00a4);
   endtask : t_drain
   task automatic t_sticky;
      bus(1'b1, 12'h810, 32'hffff_ff7f);
      rdc(12'h810, 32'h0000_00a4);
      bus(1'b1, 12'h810, 32'h80);
      rdc(12'h810, 32'h0000_0024);
      irqs(3'b100);
   endtask : t_sticky
   task automatic t_formats;
      bus(1'b1, 12'h800, 32'h87);
      bus(1'b1, 12'h840, 32'h1234);
      fork
         u_link.xfer(16'h005a, 8, got);
         begin
            repeat (30) @(posedge core_clk);
            bus(1'b0, 12'h810, 32'h0);
            chk(q & 32'h10, 32'h10);
         end
      join
      chk({16'h0, got}, 32'h34);
      rdc(12'h840, 32'h5a);
      bus(1'b1, 12'h800, 32'haf);
      bus(1'b1, 12'h840, 32'hbeef);
      u_link.xfer(16'h1357, 16, got);
      chk({16'h0, got}, 32'hef00);
      rdc(12'h840, 32'h1357);
      bus(1'b1, 12'h804, 32'h986);
      bus(1'b1, 12'h800, 32'h8f);
      bus(1'b1, 12'h840, 32'h4d2c);
      u_link.xfer(16'h0000, 16, got);
      chk({16'h0, got}, 32'h4d2c);
      rdc(12'h840, 32'h4d2c);
   endtask : t_formats
   task automatic t_strobe;
      bus(1'b1, 12'h814, 32'he0);
      repeat (4) @(posedge core_clk);
      chk({n_tx, n_rx, n_ror}, 12'h111);
      bus(1'b1, 12'h814, 32'h0);
      repeat (4) @(posedge core_clk);
      chk({n_tx, n_rx, n_ror}, 12'h111);
      rdc(12'h814, 32'h0);
   endtask : t_strobe
   task automatic t_disable;
      bus(1'b1, 12'h840, 32'h1);
      bus(1'b1, 12'h840, 32'h2);
      bus(1'b1, 12'h800, 32'h0f);
      rdc(12'h810, 32'h0000_0004);
      bus(1'b1, 12'h808, 32'hffff);
      rdc(12'h808, 32'h0);
   endtask : t_disable

   task automatic close_out;
      if (err_total == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out

   initial begin
      #400000;
      err_total++;
      close_out();
   end
   initial begin
      nrst = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 12'h0;
      avs_writedata = 32'h0;
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset();
      t_fill();
      t_link();
      t_drain();
      t_sticky();
      t_formats();
      t_strobe();
      t_disable();
      close_out();
   end
endmodule : ssfs_top_test
